/* rtl/mcu_system_control.sv */
// system control: indirect flags, port/clock config, machine cycle, carrier
`timescale 1ns/1ps
`default_nettype none
module mcu_system_control
    import sysctl_pkg::*;
(
    input  wire logic       ref_clk_i,       // oscillator clock, 25 MHz
    input  wire logic       rst_i,           // power-on reset, sync, active high
    input  wire logic       int_rst_i,       // other internal reset, one cycle
    input  wire logic       wdt_reset_i,     // watchdog overflow reset, one cycle
    input  wire sfr_req_s   sfr_req_i,       // register write request
    input  wire flag_req_s  flag_req_i,      // flag set/clear request
    input  wire logic [3:0] rd_addr_i,       // register read address
    input  wire logic       branch_i,        // current instruction is a branch
    input  wire logic       wdt_cleared_i,   // watchdog counter was reset
    input  wire logic [3:0] port_zero_i,     // port zero pin levels
    input  wire logic [3:0] port_one_i,      // port one pin levels
    output logic [3:0]      rd_data_o,       // register read data
    output logic            sys_clk_en_o,    // system clock enable pulse
    output logic [2:0]      phase_o,         // state phase in machine cycle
    output logic            instr_end_o,     // final phase of instruction
    output logic            stop_o,          // stop mode
    output logic            sleep_o,         // sleep mode
    output logic            wdt_run_o,       // watchdog may count
    output logic            wdt_restart_o,   // watchdog clear request
    output logic            clk_sw_reset_o,  // internal reset on source change
    output logic            ring_osc_en_o,   // ring oscillator enable
    output logic            xtal_en_o,       // crystal interface enable
    output logic            osc_pins_low_o,  // force oscillator pins low
    output logic            osc_pins_io_o,   // oscillator pins used as port
    output logic [1:0]      pin_map_o,       // effective pin mapping
    output logic [3:0]      port_two_o,      // port two pin output value
    output logic [3:0]      port_two_oe_o,   // port two output enable
    output logic [3:0]      port_three_o,    // port three pin output value
    output logic [3:0]      port_three_oe_o, // port three output enable
    output logic [1:0]      port_four_o,     // port four bits 3:2 output value
    output logic [1:0]      port_four_oe_o,  // port four bits 3:2 output enable
    output logic            ir_drive_o       // infrared drive pin
);

    // complete state of the block
    typedef struct packed {
        logic [7:0]  sync1;      // pin sync stage one, port one over port zero
        logic [7:0]  sync2;      // pin sync stage two
        logic [5:0]  div_cnt;    // oscillator clocks in system clock
        logic        sys_en;     // system clock enable
        logic [2:0]  phase;      // machine cycle phase
        logic        second_mc;  // in second cycle of a branch
        logic        instr_end;  // final phase strobe
        sfr_req_s    sfr_pend;   // write waiting for final phase
        flag_req_s   flag_pend;  // flag op waiting for final phase
        cpu_mode_e   mode;       // power mode
        logic [15:0] flags;      // indirect flag bank
        logic [3:0]  clk_cfg;    // clock configuration
        logic [3:0]  port_cfg;   // port configuration
        logic [3:0]  car_ctrl;   // carrier control
        logic        sw_rst;     // source change reset pulse
        logic [3:0]  rd_data;    // read data
        logic [3:0]  p2_o;       // port two value
        logic [3:0]  p2_oe;      // port two enable
        logic [3:0]  p3_oe;      // port three enable
        logic [1:0]  p4_oe;      // port four enable
        logic        osc_low;    // oscillator pins low
        logic        xtal_en;    // crystal enable
        logic        ring_en;    // ring enable
        logic [1:0]  map;        // effective pin map
        logic        ir;         // infrared drive
    } ctl_state_s;

    // power-on value; ring oscillator on, flags at their defaults
    localparam ctl_state_s POR_STATE = '{
        sync1:     8'hFF,
        sync2:     8'hFF,
        div_cnt:   6'h00,
        sys_en:    1'b0,
        phase:     3'h0,
        second_mc: 1'b0,
        instr_end: 1'b0,
        sfr_pend:  '0,
        flag_pend: '0,
        mode:      MODE_ACTIVE,
        flags:     FLAGS_RST,
        clk_cfg:   CLOCK_CFG_RST,
        port_cfg:  PORT_CFG_RST,
        car_ctrl:  CARRIER_CTRL_RST,
        sw_rst:    1'b0,
        rd_data:   4'h0,
        p2_o:      4'h0,
        p2_oe:     4'h0,
        p3_oe:     4'h0,
        p4_oe:     2'h0,
        osc_low:   1'b0,
        xtal_en:   1'b0,
        ring_en:   1'b1,
        map:       PC_MAP_DEFAULT,
        ir:        1'b1
    };

    ctl_state_s s_r;       // registered state
    ctl_state_s s_nxt;     // next state
    logic       carrier;   // internal carrier signal

    // mask for a flag index, used by set and clear paths
    function automatic logic [15:0] flag_mask(input logic [3:0] idx);
        flag_mask = 16'h0001 << idx;
    endfunction : flag_mask

    // carrier pattern generator runs on the system clock enable
    carrier_gen u_carrier (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .tick_i    (s_r.sys_en),
        .ctrl_i    (s_r.car_ctrl),
        .carrier_o (carrier)
    );

    // next-state logic
    always_comb begin
        logic [5:0]  div_last;   // last count of divider
        logic        commit;     // instruction ends this cycle
        logic        last_mc;    // machine cycle is the last one
        logic        map_open;   // protected writes allowed
        logic        int_rst;    // an internal reset applies
        logic [15:0] fmask;      // selected flag
        div_last = 6'h00;
        commit   = 1'b0;
        last_mc  = 1'b0;
        map_open = 1'b0;
        int_rst  = 1'b0;
        fmask    = 16'h0000;
        s_nxt    = s_r;

        // two-stage sync of port zero/one wake levels; stage one feeds only stage two
        // pins are synced one by one, since gating them first could glitch
        s_nxt.sync1 = {port_one_i, port_zero_i};
        s_nxt.sync2 = s_r.sync1;

        // divider: system clock = oscillator / 2^field
        div_last = 6'((7'h01 << s_r.clk_cfg[CK_DIV_MSB:0]) - 7'h01);
        s_nxt.sys_en = 1'b0;
        if (s_r.mode != MODE_STOP) begin
            if (s_r.div_cnt >= div_last) begin
                s_nxt.div_cnt = 6'h00;
                s_nxt.sys_en  = 1'b1;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 6'h01;
            end
        end

        // hold requests until the instruction's final phase
        if (sfr_req_i.wr) begin
            s_nxt.sfr_pend = sfr_req_i;
        end
        if (flag_req_i.set || flag_req_i.clr) begin
            s_nxt.flag_pend = flag_req_i;
        end

        // machine cycle sequencer, halted in sleep and stop
        s_nxt.instr_end = 1'b0;
        last_mc = !branch_i || s_r.second_mc;
        if (s_r.sys_en && s_r.mode == MODE_ACTIVE) begin
            if (s_r.phase == FINAL_PHASE) begin
                s_nxt.phase = 3'h0;
                if (last_mc) begin
                    s_nxt.second_mc = 1'b0;
                    commit          = 1'b1;
                end else begin
                    s_nxt.second_mc = 1'b1;
                end
            end else begin
                s_nxt.phase = s_r.phase + 3'h1;
            end
        end
        s_nxt.instr_end = commit;

        // commit of pending register write at the final phase
        map_open = s_r.flags[FLG_MAP_HIGH] && !s_r.flags[FLG_MAP_LOW];
        s_nxt.sw_rst = 1'b0;
        if (commit && s_r.sfr_pend.wr) begin
            if (!sfr_req_i.wr) begin
                s_nxt.sfr_pend.wr = 1'b0;
            end
            case (s_r.sfr_pend.addr)
                ADDR_CARRIER_CTRL: begin
                    s_nxt.car_ctrl = s_r.sfr_pend.data;
                end
                ADDR_PORT_CFG: begin
                    s_nxt.port_cfg = s_r.sfr_pend.data;
                end
                ADDR_CLOCK_CFG: begin
                    s_nxt.clk_cfg[CK_SRC_BIT] = s_r.sfr_pend.data[CK_SRC_BIT];
                    // undefined ratio is ignored, old ratio kept
                    if (s_r.sfr_pend.data[CK_DIV_MSB:0] != CK_DIV_UNDEF) begin
                        s_nxt.clk_cfg[CK_DIV_MSB:0] = s_r.sfr_pend.data[CK_DIV_MSB:0];
                    end
                    // changing the source restarts the device
                    s_nxt.sw_rst = s_r.sfr_pend.data[CK_SRC_BIT] != s_r.clk_cfg[CK_SRC_BIT];
                end
                ADDR_FLASH_PROG_CTRL: begin
                    // the flash control write itself is outside; with map high set and low clear it forces run
                    if (map_open) begin
                        s_nxt.flags[FLG_WDT_RUN] = 1'b1;
                    end
                end
                default: begin
                    // other registers live elsewhere
                end
            endcase
        end

        // commit of pending flag operation
        if (commit && (s_r.flag_pend.set || s_r.flag_pend.clr)) begin
            if (!(flag_req_i.set || flag_req_i.clr)) begin
                s_nxt.flag_pend = '0;
            end
            fmask = flag_mask(s_r.flag_pend.idx);
            case (s_r.flag_pend.idx)
                4'(FLG_STOP): begin
                    // refused while any wake pin is low
                    if (s_r.flag_pend.set && (&s_r.sync2)) begin
                        s_nxt.mode = MODE_STOP;
                    end
                end
                4'(FLG_SLEEP): begin
                    if (s_r.flag_pend.set) begin
                        s_nxt.mode               = MODE_SLEEP;
                        s_nxt.flags[FLG_WDT_RUN] = 1'b1;
                    end
                end
                4'(FLG_WDT_RUN): begin
                    // protected: only with map high set and low clear
                    if (map_open) begin
                        s_nxt.flags[FLG_WDT_RUN] = s_r.flag_pend.set;
                    end
                end
                default: begin
                    // restart, map and port flags
                    if (s_r.flag_pend.set) begin
                        s_nxt.flags = s_nxt.flags | fmask;
                    end else begin
                        s_nxt.flags = s_nxt.flags & ~fmask;
                    end
                end
            endcase
        end

        // restart flag drops once the counter is cleared; a new set wins
        if (wdt_cleared_i && !(commit && s_r.flag_pend.set
                && s_r.flag_pend.idx == 4'(FLG_WDT_RESTART))) begin
            s_nxt.flags[FLG_WDT_RESTART] = 1'b0;
        end

        // read path shows committed configuration; flags read as zero
        case (rd_addr_i)
            ADDR_CARRIER_CTRL: s_nxt.rd_data = s_r.car_ctrl;
            ADDR_CLOCK_CFG:    s_nxt.rd_data = s_r.clk_cfg;
            ADDR_PORT_CFG:     s_nxt.rd_data = s_r.port_cfg;
            default:           s_nxt.rd_data = 4'h0;
        endcase

        // pins frozen during stop and sleep
        if (s_r.mode == MODE_ACTIVE) begin
            if (s_r.port_cfg[PC_PUSH_PULL_BIT]) begin
                // push-pull drives both levels
                s_nxt.p2_o  = s_r.flags[FLG_P2_LSB +: 4];
                s_nxt.p2_oe = 4'hF;
            end else begin
                // open drain: drive low only where the bit is zero
                s_nxt.p2_o  = 4'h0;
                s_nxt.p2_oe = ~s_r.flags[FLG_P2_LSB +: 4];
            end
            s_nxt.p3_oe = ~s_r.flags[FLG_P3_LSB +: 4];
            s_nxt.p4_oe = ~{s_r.flags[FLG_P4_BIT3], s_r.flags[FLG_P4_BIT2]};
        end

        // oscillator selection and pin use
        s_nxt.ring_en = !s_r.clk_cfg[CK_SRC_BIT];
        s_nxt.xtal_en = s_r.clk_cfg[CK_SRC_BIT] && !s_r.port_cfg[PC_OSC_IO_BIT]
                        && s_r.mode != MODE_STOP;
        s_nxt.osc_low = (s_r.mode == MODE_STOP) && !s_r.port_cfg[PC_OSC_IO_BIT];

        // reserved mapping code falls back to the default map
        if (s_r.port_cfg[PC_MAP_MSB:PC_MAP_LSB] == PC_MAP_RESERVED) begin
            s_nxt.map = PC_MAP_DEFAULT;
        end else begin
            s_nxt.map = s_r.port_cfg[PC_MAP_MSB:PC_MAP_LSB];
        end

        // led lit while carrier high
        s_nxt.ir = !carrier;

        // internal resets; in sleep only the watchdog and source-change resets apply
        int_rst = wdt_reset_i || s_r.sw_rst || (int_rst_i && s_r.mode != MODE_SLEEP);
        if (int_rst) begin
            s_nxt.phase                       = 3'h0;
            s_nxt.second_mc                   = 1'b0;
            s_nxt.instr_end                   = 1'b0;
            s_nxt.sfr_pend                    = '0;
            s_nxt.flag_pend                   = '0;
            s_nxt.mode                        = MODE_ACTIVE;
            s_nxt.flags                       = FLAGS_RST;
            s_nxt.car_ctrl                    = CARRIER_CTRL_RST;
            s_nxt.port_cfg[PC_PUSH_PULL_BIT]  = 1'b0;
            s_nxt.sw_rst                      = 1'b0;
            // clock configuration untouched
        end
    end

    // state register; power-on reset sets every field
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_r <= POR_STATE;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from state flops; port three and four values are constant zero
    assign rd_data_o       = s_r.rd_data;
    assign sys_clk_en_o    = s_r.sys_en;
    assign phase_o         = s_r.phase;
    assign instr_end_o     = s_r.instr_end;
    assign stop_o          = s_r.mode[2];   // one-hot stop bit
    assign sleep_o         = s_r.mode[1];   // one-hot sleep bit
    assign wdt_run_o       = s_r.flags[FLG_WDT_RUN];
    assign wdt_restart_o   = s_r.flags[FLG_WDT_RESTART];
    assign clk_sw_reset_o  = s_r.sw_rst;
    assign ring_osc_en_o   = s_r.ring_en;
    assign xtal_en_o       = s_r.xtal_en;
    assign osc_pins_low_o  = s_r.osc_low;
    assign osc_pins_io_o   = s_r.port_cfg[PC_OSC_IO_BIT];
    assign pin_map_o       = s_r.map;
    assign port_two_o      = s_r.p2_o;
    assign port_two_oe_o   = s_r.p2_oe;
    assign port_three_o    = 4'h0;
    assign port_three_oe_o = s_r.p3_oe;
    assign port_four_o     = 2'h0;
    assign port_four_oe_o  = s_r.p4_oe;
    assign ir_drive_o      = s_r.ir;

endmodule : mcu_system_control
`default_nettype wire

/* shared/sysctl_pkg.sv */
// package: constants, request carriers and modes for the system-control block
package sysctl_pkg;

    // special-function register offsets
    localparam logic [3:0]  ADDR_CARRIER_CTRL    = 4'h5;
    localparam logic [3:0]  ADDR_FLASH_PROG_CTRL = 4'h9;
    localparam logic [3:0]  ADDR_CLOCK_CFG       = 4'hD;
    localparam logic [3:0]  ADDR_PORT_CFG        = 4'hE;

    // reset values
    localparam logic [3:0]  CARRIER_CTRL_RST     = 4'h0;
    localparam logic [3:0]  CLOCK_CFG_RST        = 4'h0;
    localparam logic [3:0]  PORT_CFG_RST         = 4'h0;
    localparam logic [15:0] FLAGS_RST            = 16'h23FF;

    // indirect flag indices
    localparam int          FLG_STOP             = 15;
    localparam int          FLG_SLEEP            = 14;
    localparam int          FLG_WDT_RUN          = 13;
    localparam int          FLG_WDT_RESTART      = 12;
    localparam int          FLG_MAP_HIGH         = 11;
    localparam int          FLG_MAP_LOW          = 10;
    localparam int          FLG_P4_BIT2          = 9;
    localparam int          FLG_P4_BIT3          = 8;
    localparam int          FLG_P3_LSB           = 4;
    localparam int          FLG_P2_LSB           = 0;

    // clock configuration fields
    localparam int          CK_SRC_BIT           = 3;
    localparam int          CK_DIV_MSB           = 2;
    localparam logic [2:0]  CK_DIV_UNDEF         = 3'h7;

    // port configuration fields
    localparam int          PC_MAP_MSB           = 3;
    localparam int          PC_MAP_LSB           = 2;
    localparam int          PC_PUSH_PULL_BIT     = 1;
    localparam int          PC_OSC_IO_BIT        = 0;
    localparam logic [1:0]  PC_MAP_RESERVED      = 2'h3;
    localparam logic [1:0]  PC_MAP_DEFAULT       = 2'h0;

    // carrier control fields
    localparam int          CC_EN_BIT            = 3;

    // machine cycle timing
    localparam int          MC_CLOCKS            = 6;
    localparam logic [2:0]  FINAL_PHASE          = 3'(MC_CLOCKS - 1);
    localparam int          BRANCH_MCS           = 2;

    // carrier period and high-time lengths, in system clocks
    localparam logic [3:0]  CAR_PER_12           = 4'hC;
    localparam logic [3:0]  CAR_PER_11           = 4'hB;
    localparam logic [3:0]  CAR_PER_8            = 4'h8;
    localparam logic [3:0]  CAR_HI_6             = 4'h6;
    localparam logic [3:0]  CAR_HI_4             = 4'h4;
    localparam logic [3:0]  CAR_HI_3             = 4'h3;
    localparam logic [3:0]  CAR_HI_2             = 4'h2;

    // special-function register write request
    typedef struct packed {
        logic       wr;
        logic [3:0] addr;
        logic [3:0] data;
    } sfr_req_s;

    // indirect flag set/clear request
    typedef struct packed {
        logic       set;
        logic       clr;
        logic [3:0] idx;
    } flag_req_s;

    // power mode, one-hot
    typedef enum logic [2:0] {
        MODE_ACTIVE = 3'b001,
        MODE_SLEEP  = 3'b010,
        MODE_STOP   = 3'b100
    } cpu_mode_e;

endpackage : sysctl_pkg

/* rtl/carrier_gen.sv */
// carrier pattern generator for the infrared drive
`timescale 1ns/1ps
`default_nettype none
module carrier_gen
    import sysctl_pkg::*;
(
    input  wire logic       ref_clk_i,  // oscillator clock
    input  wire logic       rst_i,      // sync reset, active high
    input  wire logic       tick_i,     // system clock enable
    input  wire logic [3:0] ctrl_i,     // enable and pattern code
    output logic            carrier_o   // internal carrier signal
);

    // complete state of the generator
    typedef struct packed {
        logic [3:0] cnt;       // position in period
        logic [3:0] last_ctrl; // control seen last cycle
        logic       out;       // carrier level
    } car_state_s;

    car_state_s s_r;    // registered state
    car_state_s s_nxt;  // next state

    // period length in system clocks per pattern code
    function automatic logic [3:0] period_of(input logic [2:0] code);
        case (code)
            3'h1, 3'h5: period_of = CAR_PER_8;
            3'h6:       period_of = CAR_PER_11;
            default:    period_of = CAR_PER_12;
        endcase
    endfunction : period_of

    // high time in system clocks per pattern code
    function automatic logic [3:0] high_of(input logic [2:0] code);
        case (code)
            3'h0:       high_of = CAR_HI_4;
            3'h1:       high_of = CAR_HI_4;
            3'h2:       high_of = CAR_HI_3;
            3'h4:       high_of = CAR_HI_6;
            3'h5:       high_of = CAR_HI_2;
            3'h6:       high_of = CAR_HI_4;
            default:    high_of = CAR_HI_4;
        endcase
    endfunction : high_of

    // next-state logic
    always_comb begin
        s_nxt           = s_r;
        s_nxt.last_ctrl = ctrl_i;
        if (ctrl_i != s_r.last_ctrl) begin
            // restart so no truncated pulse leaks out
            s_nxt.cnt = 4'h0;
        end else if (tick_i) begin
            if (s_r.cnt >= period_of(ctrl_i[2:0]) - 4'h1) begin
                s_nxt.cnt = 4'h0;
            end else begin
                s_nxt.cnt = s_r.cnt + 4'h1;
            end
        end
        if (!ctrl_i[CC_EN_BIT]) begin
            s_nxt.out = 1'b0;
        end else if (ctrl_i[1:0] == 2'h3) begin
            s_nxt.out = 1'b1;
        end else begin
            // high part comes first in each period
            s_nxt.out = (s_nxt.cnt < high_of(ctrl_i[2:0]));
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign carrier_o = s_r.out;

endmodule : carrier_gen
`default_nettype wire

/* tb/sysctl_props.sv */
// checker: port-level assertions for the system-control block
`timescale 1ns/1ps
`default_nettype none
module sysctl_props (
    input wire logic       ref_clk_i,     // clock
    input wire logic       rst_i,         // reset
    input wire logic       wdt_reset_i,   // wake reset
    input wire logic [2:0] phase_o,       // phase
    input wire logic       instr_end_o,   // end pulse
    input wire logic       sleep_o,       // sleep
    input wire logic       wdt_run_o,     // run flag
    input wire logic       ring_osc_en_o, // ring on
    input wire logic       xtal_en_o,     // crystal on
    input wire logic [1:0] pin_map_o,     // mapping
    input wire logic [3:0] port_two_o,    // p2 value
    input wire logic [3:0] port_two_oe_o  // p2 enable
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // two sampled cycles spent asleep
    sequence asleep;
        sleep_o ##1 sleep_o;
    endsequence
    a_phase_range: assert property (phase_o <= 3'h5) else $error("phase past five");
    a_end_pulse: assert property (instr_end_o |=> !instr_end_o) else $error("end pulse long");
    a_map_legal: assert property (pin_map_o != 2'h3) else $error("reserved map");
    a_osc_apart: assert property (!(xtal_en_o && ring_osc_en_o)) else $error("both osc on");
    a_drain_low: assert property (port_two_oe_o != 4'hF |-> port_two_o == 4'h0) else $error("drove high");
    a_sleep_run: assert property (sleep_o |-> wdt_run_o) else $error("run not forced");
    a_sleep_kept: assert property (sleep_o && !wdt_reset_i |=> sleep_o) else $error("woke early");
    a_pins_held: assert property (asleep |-> $stable(port_two_oe_o)) else $error("pins moved");
endmodule : sysctl_props
bind mcu_system_control sysctl_props sysctl_props_i (.*);
`default_nettype wire

/* tb/pin_partner.sv */
// pin partner: pull-ups on port pins, keys pulling port zero low
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input  wire logic [3:0] key_low_i,  // keys pressed
    input  wire logic [3:0] drive_i,    // p2 value
    input  wire logic [3:0] drive_oe_i, // p2 enable
    output logic      [3:0] zero_o,     // p0 level
    output logic      [3:0] one_o,      // p1 level
    output logic      [3:0] two_o       // p2 level
);
    // pull-ups win wherever nothing drives
    assign zero_o = ~key_low_i;
    assign one_o  = 4'hF;
    assign two_o  = (drive_oe_i & drive_i) | ~drive_oe_i;
endmodule : pin_partner
`default_nettype wire

/* tb/mcu_system_control_tb.sv */
// testbench: drives the system-control block and checks its ports
`timescale 1ns/1ps
`default_nettype none
module mcu_system_control_tb;
    import sysctl_pkg::*;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, irst = 1'b0, wrst = 1'b0, ie, stop, slp, run, ring, xt, ir;
    logic rd_v = 1'b0, rd_d = 1'b0, br = 1'b0, wclr = 1'b0, rs;
    logic [3:0] ra = 4'h0, keys = 4'h0, rdat, p2, oe, p0, p1, pin, d, p3;
    logic [1:0] pmap;
    sfr_req_s sfr = '0;
    flag_req_s flg = '0;
    logic [3:0] exp_q[$];
    int failures = 0, num_checks = 0, seed = 32'h4938, n, m;
    int lit[9] = '{176, 264, 132, 528, 264, 132, 192, 528, 0};
    mcu_system_control mcu_system_control_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .int_rst_i(irst),
        .wdt_reset_i(wrst), .sfr_req_i(sfr), .flag_req_i(flg), .rd_addr_i(ra), .branch_i(br),
        .wdt_cleared_i(wclr), .port_zero_i(p0), .port_one_i(p1), .rd_data_o(rdat), .sys_clk_en_o(),
        .phase_o(), .instr_end_o(ie), .stop_o(stop), .sleep_o(slp), .wdt_run_o(run), .wdt_restart_o(rs),
        .clk_sw_reset_o(), .ring_osc_en_o(ring), .xtal_en_o(xt), .osc_pins_low_o(), .osc_pins_io_o(),
        .pin_map_o(pmap), .port_two_o(p2), .port_two_oe_o(oe), .port_three_o(), .port_three_oe_o(p3),
        .port_four_o(), .port_four_oe_o(), .ir_drive_o(ir));
    pin_partner pin_partner_i (.key_low_i(keys), .drive_i(p2), .drive_oe_i(oe), .zero_o(p0), .one_o(p1), .two_o(pin));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    // wait n instruction ends, bounded, then let pin flops land
    task automatic settle(input int n);
        int k;
        k = 0;
        repeat (n) begin
            // pulse is looked at mid-cycle, away from the edge that launches it
            @(negedge ref_clk_i);
            while (ie !== 1'b1 && k < 99) begin
                @(negedge ref_clk_i);
                k++;
            end
        end
        if (k >= 99) begin
            failures++;
            tally_and_finish;
        end
        repeat (3) @(posedge ref_clk_i);
    endtask : settle
    task automatic wr(input logic [3:0] a, input logic [3:0] v, input int n = 2);
        sfr <= '{1'b1, a, v};
        @(posedge ref_clk_i);
        sfr.wr <= 1'b0;
        settle(n);
    endtask : wr
    task automatic fl(input logic s, input logic [3:0] i, input int n = 2);
        flg <= '{s, !s, i};
        @(posedge ref_clk_i);
        flg <= '0;
        settle(n);
    endtask : fl
    // read note goes on the queue, watcher compares a cycle later
    task automatic rd(input logic [3:0] a, input logic [3:0] want);
        ra <= a;
        rd_v <= 1'b1;
        exp_q.push_back(want);
        @(posedge ref_clk_i);
        rd_v <= 1'b0;
        @(posedge ref_clk_i);
    endtask : rd
    task automatic kick(input logic w);
        irst <= !w;
        wrst <= w;
        @(posedge ref_clk_i);
        {irst, wrst} <= 2'h0;
        repeat (4) @(posedge ref_clk_i);
    endtask : kick
    always @(posedge ref_clk_i) begin
        rd_d <= rd_v;
        if (rd_d) check(rdat, exp_q.pop_front());
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        check({run, ring, ir, stop, oe}, 8'hE0);
        rd(ADDR_CARRIER_CTRL, 4'h0);
        rd(ADDR_CLOCK_CFG, 4'h0);
        rd(ADDR_PORT_CFG, 4'h0);
        rd(4'h0, 4'h0);
        repeat (3) begin
            d = 4'($random(seed));
            wr(ADDR_CARRIER_CTRL, d);
            rd(ADDR_CARRIER_CTRL, d);
            wr(ADDR_PORT_CFG, d);
            rd(ADDR_PORT_CFG, d);
            check(pmap, d[3:2] == 2'h3 ? 2'h0 : d[3:2]);
        end
        wr(ADDR_PORT_CFG, 4'h6);
        fl(1'b0, 4'h0);
        fl(1'b0, 4'h4);
        check({oe, p2, p3}, 12'hFE1);
        wr(ADDR_PORT_CFG, 4'h4);
        check({oe, pin}, 8'h1E);
        wr(ADDR_PORT_CFG, 4'h6);
        fl(1'b0, 4'hD);
        check(run, 1'b1);
        fl(1'b1, 4'hB);
        fl(1'b0, 4'hD);
        check(run, 1'b0);
        wr(ADDR_FLASH_PROG_CTRL, 4'h0);
        check(run, 1'b1);
        fl(1'b0, 4'hD);
        fl(1'b1, 4'hE, 1);
        check({slp, run}, 2'h3);
        kick(1'b0);
        check(slp, 1'b1);
        kick(1'b1);
        check({slp, run, oe, p3}, 10'h100);
        rd(ADDR_PORT_CFG, 4'h4);
        keys <= 4'h2;
        fl(1'b1, 4'hF);
        check(stop, 1'b0);
        keys <= 4'h0;
        fl(1'b1, 4'hF, 1);
        check(stop, 1'b1);
        kick(1'b0);
        wr(ADDR_CLOCK_CFG, 4'h8);
        check({stop, xt, ring}, 3'h2);
        rd(ADDR_CLOCK_CFG, 4'h8);
        fl(1'b1, 4'hC);
        check(rs, 1'b1);
        wclr <= 1'b1;
        @(posedge ref_clk_i);
        wclr <= 1'b0;
        @(posedge ref_clk_i);
        check(rs, 1'b0);
        for (int i = 0; i < 9; i++) begin
            // odd passes run branch instructions: two machine cycles each
            br <= i[0];
            wr(ADDR_CARRIER_CTRL, 4'(i ^ 8));
            n = 0;
            m = 0;
            repeat (528) begin
                @(posedge ref_clk_i);
                n += int'(ir === 1'b0);
                m += int'(ie === 1'b1);
            end
            check(12'(n), 12'(lit[i]));
            check(12'(m), i[0] ? 12'h02C : 12'h058);
        end
        tally_and_finish;
    end
endmodule : mcu_system_control_tb
`default_nettype wire
